// >>> bench/cefmb_host_model.sv
// Host processor model issuing register reads and writes on the register port
`timescale 1ns/1ps
module cefmb_host_model import cefmb_pkg::*; (
  input wire logic clk, // Device clock
  output cefmb_reg_req_s reg_req, // Register request towards the bank
  input wire logic [7:0] reg_rdata, // Read data from the bank
  input wire logic reg_rvalid // Read data qualifier
);
  // Idle bus shows inverted last values so stale data never looks valid
  initial begin
    reg_req = '{addr: 8'hFF, wr: 1'b0, rd: 1'b0, wdata: 8'hFF};
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_req.addr = a;
    reg_req.wdata = d;
    reg_req.wr = 1'b1;
    @(posedge clk);
    #1;
    reg_req.wr = 1'b0;
    reg_req.addr = ~a;
    reg_req.wdata = ~d;
  endtask

  // Answer is registered at the same edge that takes the strobe, sampled once settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    #1;
    reg_req.addr = a;
    reg_req.rd = 1'b1;
    @(posedge clk);
    #1;
    reg_req.rd = 1'b0;
    reg_req.addr = ~a;
    v = reg_rvalid;
    d = reg_rdata;
  endtask

  // Write, then read of the same offset in the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic v);
    @(posedge clk);
    #1;
    reg_req.addr = a;
    reg_req.wdata = d;
    reg_req.wr = 1'b1;
    @(posedge clk);
    #1;
    reg_req.wr = 1'b0;
    reg_req.rd = 1'b1;
    @(posedge clk);
    #1;
    reg_req.rd = 1'b0;
    reg_req.addr = ~a;
    reg_req.wdata = ~d;
    v = reg_rvalid;
    q = reg_rdata;
  endtask
endmodule // cefmb_host_model

// >>> bench/tb.sv
// Self-checking testbench of the event flag and mask bank
`timescale 1ns/1ps
module tb import cefmb_pkg::*;;
  logic clk;
  logic rstn;
  cefmb_events_s event_pins;
  logic [7:0] cs_flags;
  logic [7:0] ft_flags;
  logic [7:0] ca_flags;
  cefmb_reg_req_s reg_req;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic irq;
  int fail_count = 0;
  int total_checks = 0;
  logic [7:0] bb_data;
  logic bb_valid;
  logic [7:0] pats [3] = '{8'hA5, 8'h5A, 8'h00};
  logic [7:0] ext_addr [8] = '{8'h07, 8'h07, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h09};
  logic [7:0] ext_bit [8] = '{8'h40, 8'h01, 8'h80, 8'h20, 8'h10, 8'h08, 8'h01, 8'h01};

  cefmb_top cefmb_top_i (
    .clk(clk),
    .rstn(rstn),
    .event_pins(event_pins),
    .charge_status_flags(cs_flags),
    .fault_thermal_flags(ft_flags),
    .converter_alarm_flags(ca_flags),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .irq(irq)
  );

  cefmb_host_model cefmb_host_model_i (
    .clk(clk),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    logic v;
    cefmb_host_model_i.rd(a, d, v);
    check({what, " valid"}, 8'h01, {7'h00, v});
    check(what, exp, d);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Generous bound, the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("mismatch watchdog expected done seen timeout");
    summarize;
  end

  initial begin
    rstn = 1'b0;
    event_pins = '0;
    cs_flags = 8'h00;
    ft_flags = 8'h00;
    ca_flags = 8'h00;
    repeat (5) @(posedge clk);
    #1;
    check("irq in reset", 8'h00, {7'h00, irq});
    rstn = 1'b1;
    rd_chk(CEFMB_ADDR_MASK_CHARGE, 8'h00, "mask charge reset");
    rd_chk(CEFMB_ADDR_MASK_FAULT, 8'h00, "mask fault reset");
    rd_chk(CEFMB_ADDR_MASK_ALARM, 8'h71, "mask alarm reset");
    rd_chk(CEFMB_ADDR_EVENT_FLAGS, 8'h00, "flags reset");
    rd_chk(8'h0B, CEFMB_RDATA_UNMAPPED, "unmapped read");
    $display("test reset values done");
    for (int i = 0; i < CEFMB_MASK_N; i++) begin
      for (int p = 0; p < 3; p++) begin
        cefmb_host_model_i.wr(CEFMB_MASK_ADDR[i], pats[p]);
        rd_chk(CEFMB_MASK_ADDR[i], pats[p], "mask readback");
      end
    end
    cefmb_host_model_i.wr_rd(CEFMB_ADDR_MASK_CHARGE, 8'h3C, bb_data, bb_valid);
    check("back-to-back valid", 8'h01, {7'h00, bb_valid});
    check("back-to-back readback", 8'h3C, bb_data);
    cefmb_host_model_i.wr(CEFMB_ADDR_MASK_CHARGE, 8'h00);
    cefmb_host_model_i.wr(CEFMB_ADDR_EVENT_FLAGS, 8'hFF);
    rd_chk(CEFMB_ADDR_EVENT_FLAGS, 8'h00, "flags after write");
    $display("test mask access done");
    for (int i = 6; i >= 0; i--) begin
      event_pins = cefmb_events_s'(7'(1 << i));
      cyc(8);
      check("irq on event", 8'h01, {7'h00, irq});
      event_pins = '0;
      cyc(2);
      rd_chk(CEFMB_ADDR_EVENT_FLAGS, 8'(1 << i), "event flag");
      rd_chk(CEFMB_ADDR_EVENT_FLAGS, 8'h00, "flag after read");
      check("irq after read", 8'h00, {7'h00, irq});
    end
    $display("test event flags done");
    cefmb_host_model_i.wr(CEFMB_ADDR_MASK_TIMERS, 8'h40);
    event_pins.watchdog_expiry_event = 1'b1;
    cyc(8);
    check("irq masked event", 8'h00, {7'h00, irq});
    event_pins = '0;
    cefmb_host_model_i.wr(CEFMB_ADDR_MASK_TIMERS, 8'h00);
    cyc(3);
    check("irq after unmask", 8'h01, {7'h00, irq});
    rd_chk(CEFMB_ADDR_EVENT_FLAGS, 8'h40, "masked flag kept");
    $display("test masked event done");
    for (int k = 0; k < 8; k++) begin
      cs_flags = (ext_addr[k] == 8'h07) ? ext_bit[k] : 8'h00;
      ft_flags = (ext_addr[k] == 8'h08) ? ext_bit[k] : 8'h00;
      ca_flags = (ext_addr[k] == 8'h09) ? ext_bit[k] : 8'h00;
      cyc(3);
      check("irq unmasked bank", 8'h01, {7'h00, irq});
      cefmb_host_model_i.wr(ext_addr[k], ext_bit[k]);
      cyc(3);
      check("irq masked bank", 8'h00, {7'h00, irq});
      cefmb_host_model_i.wr(ext_addr[k], 8'h00);
      cs_flags = 8'h00;
      ft_flags = 8'h00;
      ca_flags = 8'h00;
      cyc(3);
    end
    $display("test bank masking done");
    cefmb_host_model_i.wr(CEFMB_ADDR_MASK_CHARGE, 8'hFF);
    rstn = 1'b0;
    cyc(2);
    rstn = 1'b1;
    rd_chk(CEFMB_ADDR_MASK_CHARGE, 8'h00, "mask charge rereset");
    rd_chk(CEFMB_ADDR_MASK_ALARM, 8'h71, "mask alarm rereset");
    $display("test second reset done");
    summarize;
  end
endmodule // tb

// >>> design/cefmb_event_sync.sv
// Three-stage synchroniser and rising-edge detector for the asynchronous event inputs
`timescale 1ns/1ps
module cefmb_event_sync import cefmb_pkg::*; #(
  parameter int WIDTH = CEFMB_EVENT_N
) (
  input wire logic clk, // Device clock
  input wire logic rstn, // Async reset, active low
  input wire logic [WIDTH-1:0] raw, // Event levels from outside the clock domain
  output logic [WIDTH-1:0] hit // One-cycle pulse on a settled rising level
);

  genvar k;
  generate
    for (k = 0; k < WIDTH; k++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      logic settled;
      wire agree = (s2 == s3);
      wire rise = agree && s3 && !settled;
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          settled <= 1'b0;
          hit[k] <= 1'b0;
        end else begin
          s1 <= raw[k];
          s2 <= s1;
          s3 <= s2;
          // Only a level seen on two late stages counts
          if (agree) begin
            settled <= s3;
          end
          hit[k] <= rise;
        end
      end
    end
  endgenerate

endmodule // cefmb_event_sync

// >>> design/cefmb_pkg.sv
// Package: register map, reset values, field positions and carriers of the event flag and mask bank
package cefmb_pkg;

  localparam int CEFMB_DATA_W = 8;
  localparam int CEFMB_EVENT_N = 7;
  localparam int CEFMB_MASK_N = 4;
  localparam int CEFMB_SYNC_STAGES = 3;

  // Register offsets on the serial control bus
  localparam logic [7:0] CEFMB_ADDR_EVENT_FLAGS = 8'h06;
  localparam logic [7:0] CEFMB_ADDR_MASK_CHARGE = 8'h07;
  localparam logic [7:0] CEFMB_ADDR_MASK_FAULT = 8'h08;
  localparam logic [7:0] CEFMB_ADDR_MASK_ALARM = 8'h09;
  localparam logic [7:0] CEFMB_ADDR_MASK_TIMERS = 8'h0A;

  // Values after reset
  localparam logic [7:0] CEFMB_RST_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] CEFMB_RST_MASK_CHARGE = 8'h00;
  localparam logic [7:0] CEFMB_RST_MASK_FAULT = 8'h00;
  localparam logic [7:0] CEFMB_RST_MASK_ALARM = 8'h71;
  localparam logic [7:0] CEFMB_RST_MASK_TIMERS = 8'h00;
  localparam logic [7:0] CEFMB_RDATA_UNMAPPED = 8'h00;

  // Mask bank tables, index 0 is the charge status mask
  localparam logic [CEFMB_MASK_N-1:0][7:0] CEFMB_MASK_ADDR = {
    CEFMB_ADDR_MASK_TIMERS, CEFMB_ADDR_MASK_ALARM, CEFMB_ADDR_MASK_FAULT, CEFMB_ADDR_MASK_CHARGE};
  localparam logic [CEFMB_MASK_N-1:0][7:0] CEFMB_MASK_RST = {
    CEFMB_RST_MASK_TIMERS, CEFMB_RST_MASK_ALARM, CEFMB_RST_MASK_FAULT, CEFMB_RST_MASK_CHARGE};

  // Event flag field positions
  localparam int CEFMB_BIT_WATCHDOG = 6;
  localparam int CEFMB_BIT_CHARGE_TIMER = 5;
  localparam int CEFMB_BIT_AUX_OCP = 4;
  localparam int CEFMB_BIT_ILIM_OPEN = 3;
  localparam int CEFMB_BIT_WAKE_FIRST = 2;
  localparam int CEFMB_BIT_WAKE_SECOND = 1;
  localparam int CEFMB_BIT_RESET_WARN = 0;

  // Charge status mask field positions
  localparam int CEFMB_BIT_CONST_VOLTAGE = 6;
  localparam int CEFMB_BIT_INPUT_POWER_GOOD = 0;
  // Fault and thermal mask field positions
  localparam int CEFMB_BIT_INPUT_OVERVOLTAGE = 7;
  localparam int CEFMB_BIT_THERMISTOR_HOT = 0;

  // Event pins, bit order equals flag bit order
  typedef struct packed {
    logic watchdog_expiry_event;
    logic charge_timer_expiry_event;
    logic aux_regulator_overcurrent_event;
    logic current_limit_pin_open_event;
    logic button_wake_first_event;
    logic button_wake_second_event;
    logic button_reset_warning_event;
  } cefmb_events_s;

  // Register port request from the serial bus slave
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } cefmb_reg_req_s;

endpackage

// >>> design/cefmb_top.sv
// Event flag register and interrupt mask bank with interrupt output
// Operation
// [R1] Watchdog expiry sets flag bit 6; nothing else sets it.
// [R2] Charge safety timer expiry sets flag bit 5.
// [R3] Auxiliary regulator overcurrent sets flag bit 4; zero means regulator normal.
// [R4] Open maximum-current setting input sets flag bit 3.
// [R5] First push-button wake timer expiry sets flag bit 2.
// [R6] Second push-button wake timer expiry sets flag bit 1.
// [R7] Push-button reset warning timer expiry sets flag bit 0.
// [R8] Charge status mask bits 6..0 block CV, done, ilim, path, vin-reg, thermal, power-good.
// [R9] Charge status mask sits at 0x7, resets to 0x0.
// [R10] Fault mask: bit 7 input OV, bit 5 battery OC, bit 4 battery UV.
// [R11] Fault mask bits 3..0 block thermistor cold, cool, warm, hot.
// [R12] Fault mask sits at 0x8, resets to 0x0.
// [R13] Alarm mask sits at 0x9, resets to 0x71.
// [R14] Mask bits read and write; one blocks interrupt, zero enables.
// [R15] Flag register clears on host read and resets to zero.
// [R16] Flags stay set until read; masking never stops recording.
// [R17] Interrupt asserts while any flag is set with its mask clear.
`timescale 1ns/1ps
module cefmb_top import cefmb_pkg::*; (
  input wire logic clk, // Device clock, 100 MHz
  input wire logic rstn, // Async reset, active low
  input wire cefmb_events_s event_pins, // Expiry and fault levels, asynchronous
  input wire logic [7:0] charge_status_flags, // Pending flags of the charge status flag register
  input wire logic [7:0] fault_thermal_flags, // Pending flags of the fault and thermal flag register
  input wire logic [7:0] converter_alarm_flags, // Pending flags of the converter alarm flag register
  input wire cefmb_reg_req_s reg_req, // Register access from the serial bus slave
  output logic [7:0] reg_rdata, // Read data, valid with reg_rvalid
  output logic reg_rvalid, // One-cycle pulse, one cycle after a read
  output logic irq // Interrupt request, active high
);

  logic [CEFMB_EVENT_N-1:0] event_hit;
  logic [CEFMB_EVENT_N-1:0] event_flags;
  logic [CEFMB_MASK_N-1:0][7:0] mask;

  cefmb_event_sync #(
    .WIDTH(CEFMB_EVENT_N)
  ) u_event_sync (
    .clk(clk),
    .rstn(rstn),
    .raw(event_pins),
    .hit(event_hit)
  );

  // Address decode
  wire sel_flags = (reg_req.addr == CEFMB_ADDR_EVENT_FLAGS);
  wire rd_flags = reg_req.rd && sel_flags;
  logic [CEFMB_MASK_N-1:0] sel_mask;
  logic [CEFMB_MASK_N-1:0] wr_mask;

  // Set wins over the read clear, so an event in the read cycle survives
  wire [CEFMB_EVENT_N-1:0] kept_flags = rd_flags ? {CEFMB_EVENT_N{1'b0}} : event_flags; // [R15]
  wire [CEFMB_EVENT_N-1:0] next_event_flags = kept_flags | event_hit; // [R16]

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_flags <= CEFMB_RST_EVENT_FLAGS[CEFMB_EVENT_N-1:0]; // [R15]
    end else begin
      event_flags <= next_event_flags; // [R1] [R2] [R3] [R4] [R5] [R6] [R7]
    end
  end

  genvar m;
  generate
    for (m = 0; m < CEFMB_MASK_N; m++) begin : g_mask
      assign sel_mask[m] = (reg_req.addr == CEFMB_MASK_ADDR[m]);
      assign wr_mask[m] = reg_req.wr && sel_mask[m];
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          mask[m] <= CEFMB_MASK_RST[m]; // [R9] [R12] [R13]
        end else if (wr_mask[m]) begin
          mask[m] <= reg_req.wdata; // [R14]
        end
      end
    end
  endgenerate

  // Read data select; unmapped offsets read zero
  wire [7:0] flags_word = {1'b0, event_flags};
  wire [7:0] next_rdata = sel_flags ? flags_word :
                          sel_mask[0] ? mask[0] :
                          sel_mask[1] ? mask[1] :
                          sel_mask[2] ? mask[2] :
                          sel_mask[3] ? mask[3] : CEFMB_RDATA_UNMAPPED;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= CEFMB_RDATA_UNMAPPED;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= next_rdata; // [R14]
      end
    end
  end

  // Masks gate only the request, never the flag storage
  wire [7:0] open_charge = charge_status_flags & ~mask[0]; // [R8]
  wire [7:0] open_fault = fault_thermal_flags & ~mask[1]; // [R10] [R11]
  wire [7:0] open_alarm = converter_alarm_flags & ~mask[2];
  wire [7:0] open_timers = flags_word & ~mask[3];
  wire next_irq = |{open_charge, open_fault, open_alarm, open_timers}; // [R17]

  // Registered, so irq trails its cause by one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq; // [R17]
    end
  end

  // Helper: high only at the first edge after reset release
  logic first_cycle;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= 1'b0;
    end
  end

  property p_flag_capture(int b);
    @(posedge clk) disable iff (!rstn)
    event_hit[b] |=> event_flags[b];
  endproperty

  property p_flag_cause(int b);
    @(posedge clk) disable iff (!rstn)
    $rose(event_flags[b]) |-> $past(event_hit[b]);
  endproperty

  a_watchdog_flag_set: assert property (p_flag_capture(CEFMB_BIT_WATCHDOG)) // [R1]
    else $error("watchdog expiry not recorded");

  a_watchdog_flag_cause: assert property (p_flag_cause(CEFMB_BIT_WATCHDOG)) // [R1]
    else $error("watchdog flag set without expiry");

  a_charge_timer_flag: assert property (p_flag_capture(CEFMB_BIT_CHARGE_TIMER)) // [R2]
    else $error("charge timer expiry not recorded");

  a_aux_ocp_flag: assert property (p_flag_capture(CEFMB_BIT_AUX_OCP)) // [R3]
    else $error("regulator overcurrent not recorded");

  a_aux_ocp_cause: assert property (p_flag_cause(CEFMB_BIT_AUX_OCP)) // [R3]
    else $error("regulator overcurrent flag set while normal");

  a_ilim_open_flag: assert property (p_flag_capture(CEFMB_BIT_ILIM_OPEN)) // [R4]
    else $error("current limit pin open not recorded");

  a_wake_first_flag: assert property (p_flag_capture(CEFMB_BIT_WAKE_FIRST)) // [R5]
    else $error("first wake timer expiry not recorded");

  a_wake_second_flag: assert property (p_flag_capture(CEFMB_BIT_WAKE_SECOND)) // [R6]
    else $error("second wake timer expiry not recorded");

  a_reset_warn_flag: assert property (p_flag_capture(CEFMB_BIT_RESET_WARN)) // [R7]
    else $error("reset warning expiry not recorded");

  a_charge_timer_cause: assert property (p_flag_cause(CEFMB_BIT_CHARGE_TIMER)) // [R2]
    else $error("charge timer flag set without expiry");

  a_ilim_open_cause: assert property (p_flag_cause(CEFMB_BIT_ILIM_OPEN)) // [R4]
    else $error("current limit pin flag set without fault");

  a_wake_first_cause: assert property (p_flag_cause(CEFMB_BIT_WAKE_FIRST)) // [R5]
    else $error("first wake flag set without expiry");

  a_wake_second_cause: assert property (p_flag_cause(CEFMB_BIT_WAKE_SECOND)) // [R6]
    else $error("second wake flag set without expiry");

  a_reset_warn_cause: assert property (p_flag_cause(CEFMB_BIT_RESET_WARN)) // [R7]
    else $error("reset warning flag set without expiry");

  // Pin level held six cycles must reach the flag by the last cycle of the hold or the cycle after
  sequence s_pin_watchdog_high;
    event_pins.watchdog_expiry_event [*6];
  endsequence

  a_pin_to_flag_path: assert property ( // [R1]
    @(posedge clk) disable iff (!rstn)
    (!event_pins.watchdog_expiry_event ##1 s_pin_watchdog_high) |-> ##[0:1] event_flags[CEFMB_BIT_WATCHDOG])
    else $error("watchdog pin never reached its flag");

  a_reset_masks_value: assert property ( // [R9]
    @(posedge clk) disable iff (!rstn)
    first_cycle |-> (mask[0] == CEFMB_RST_MASK_CHARGE) && (mask[1] == CEFMB_RST_MASK_FAULT))
    else $error("charge or fault mask wrong after reset");

  a_reset_alarm_mask: assert property ( // [R13]
    @(posedge clk) disable iff (!rstn)
    first_cycle |-> (mask[2] == CEFMB_RST_MASK_ALARM) && (event_flags == '0))
    else $error("alarm mask or flags wrong after reset");

  a_fault_mask_addr: assert property ( // [R12]
    @(posedge clk) disable iff (!rstn)
    (reg_req.wr && reg_req.addr == CEFMB_ADDR_MASK_FAULT) |=> (mask[1] == $past(reg_req.wdata)))
    else $error("fault mask write at its offset lost");

  sequence s_charge_mask_write;
    reg_req.wr && !reg_req.rd && (reg_req.addr == CEFMB_ADDR_MASK_CHARGE);
  endsequence

  sequence s_charge_mask_read;
    reg_req.rd && !reg_req.wr && (reg_req.addr == CEFMB_ADDR_MASK_CHARGE);
  endsequence

  a_mask_write_readback: assert property ( // [R14]
    @(posedge clk) disable iff (!rstn)
    (s_charge_mask_write ##1 s_charge_mask_read) |=> reg_rvalid && (reg_rdata == $past(reg_req.wdata, 2)))
    else $error("charge mask readback differs from written value");

  a_const_voltage_block: assert property ( // [R8]
    @(posedge clk) disable iff (!rstn)
    (charge_status_flags == 8'h40 && mask[0][CEFMB_BIT_CONST_VOLTAGE] && fault_thermal_flags == 8'h00 &&
     (converter_alarm_flags & ~mask[2]) == 8'h00 && (flags_word & ~mask[3]) == 8'h00) |=> !irq)
    else $error("masked constant-voltage event raised interrupt");

  a_overvoltage_enable: assert property ( // [R10]
    @(posedge clk) disable iff (!rstn)
    (fault_thermal_flags[CEFMB_BIT_INPUT_OVERVOLTAGE] && !mask[1][CEFMB_BIT_INPUT_OVERVOLTAGE]) |=> irq)
    else $error("unmasked input overvoltage gave no interrupt");

  a_thermistor_hot_enable: assert property ( // [R11]
    @(posedge clk) disable iff (!rstn)
    (fault_thermal_flags[CEFMB_BIT_THERMISTOR_HOT] && !mask[1][CEFMB_BIT_THERMISTOR_HOT]) |=> irq)
    else $error("unmasked thermistor hot event gave no interrupt");

  a_read_clears_flags: assert property ( // [R15]
    @(posedge clk) disable iff (!rstn)
    rd_flags |=> reg_rvalid && (reg_rdata == {1'b0, $past(event_flags)}) && (event_flags == $past(event_hit)))
    else $error("flag read did not return and clear the flags");

  a_flag_holds_unread: assert property ( // [R16]
    @(posedge clk) disable iff (!rstn)
    (event_flags != '0 && !rd_flags) |=> ((event_flags & $past(event_flags)) == $past(event_flags)))
    else $error("flag dropped without a read");

  a_mask_keeps_record: assert property ( // [R16]
    @(posedge clk) disable iff (!rstn)
    (event_hit[CEFMB_BIT_WATCHDOG] && mask[3][CEFMB_BIT_WATCHDOG]) |=> event_flags[CEFMB_BIT_WATCHDOG])
    else $error("masked event was not recorded");

  a_irq_quiet_idle: assert property ( // [R17]
    @(posedge clk) disable iff (!rstn)
    (charge_status_flags == 8'h00 && fault_thermal_flags == 8'h00 && converter_alarm_flags == 8'h00 &&
     event_flags == '0) |=> !irq)
    else $error("interrupt raised with nothing pending");

  a_irq_timer_flag: assert property ( // [R17]
    @(posedge clk) disable iff (!rstn)
    (event_flags[CEFMB_BIT_RESET_WARN] && !mask[3][CEFMB_BIT_RESET_WARN]) |=> irq)
    else $error("unmasked reset warning flag gave no interrupt");

  a_unmapped_reads_zero: assert property (
    @(posedge clk) disable iff (!rstn)
    (reg_req.rd && !sel_flags && sel_mask == '0) |=> reg_rvalid && (reg_rdata == CEFMB_RDATA_UNMAPPED))
    else $error("unmapped read returned nonzero");

  a_flag_msb_zero: assert property ( // [R15]
    @(posedge clk) disable iff (!rstn)
    (reg_rvalid && $past(rd_flags)) |-> !reg_rdata[7])
    else $error("flag register reserved bit read nonzero");

  a_flags_write_refused: assert property ( // [R15]
    @(posedge clk) disable iff (!rstn)
    (reg_req.wr && sel_flags && !reg_req.rd) |=> (event_flags == ($past(event_flags) | $past(event_hit))))
    else $error("write to flag register changed the flags");

  a_mask_read_answer: assert property ( // [R14]
    @(posedge clk) disable iff (!rstn)
    (reg_req.rd && sel_mask[1]) |=> reg_rvalid && (reg_rdata == $past(mask[1])))
    else $error("fault mask read returned wrong value");

  a_rdata_holds_idle: assert property ( // [R14]
    @(posedge clk) disable iff (!rstn)
    !reg_req.rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  a_rvalid_after_read: assert property ( // [R14]
    @(posedge clk) disable iff (!rstn)
    reg_rvalid |-> $past(reg_req.rd))
    else $error("read valid without a read");

  a_charge_any_enable: assert property ( // [R8]
    @(posedge clk) disable iff (!rstn)
    (|(charge_status_flags & ~mask[0])) |=> irq)
    else $error("unmasked charge status flag gave no interrupt");

  a_fault_any_enable: assert property ( // [R10] [R11]
    @(posedge clk) disable iff (!rstn)
    (|(fault_thermal_flags & ~mask[1])) |=> irq)
    else $error("unmasked fault flag gave no interrupt");

  a_fault_all_blocked: assert property ( // [R11]
    @(posedge clk) disable iff (!rstn)
    (fault_thermal_flags != 8'h00 && (fault_thermal_flags & ~mask[1]) == 8'h00 && charge_status_flags == 8'h00 &&
     converter_alarm_flags == 8'h00 && event_flags == '0) |=> !irq)
    else $error("masked fault flag raised interrupt");

  a_alarm_any_enable: assert property ( // [R17]
    @(posedge clk) disable iff (!rstn)
    (|(converter_alarm_flags & ~mask[2])) |=> irq)
    else $error("unmasked converter alarm gave no interrupt");

  a_timer_any_enable: assert property ( // [R17]
    @(posedge clk) disable iff (!rstn)
    (|(event_flags & ~mask[3][CEFMB_EVENT_N-1:0])) |=> irq)
    else $error("unmasked timer flag gave no interrupt");

  a_timer_mask_blocks: assert property ( // [R16]
    @(posedge clk) disable iff (!rstn)
    (event_flags != '0 && (flags_word & ~mask[3]) == 8'h00 && charge_status_flags == 8'h00 &&
     fault_thermal_flags == 8'h00 && (converter_alarm_flags & ~mask[2]) == 8'h00) |=> !irq)
    else $error("masked timer flag raised interrupt");

  a_charge_mask_write: assert property ( // [R9]
    @(posedge clk) disable iff (!rstn)
    (reg_req.wr && reg_req.addr == CEFMB_ADDR_MASK_CHARGE) |=> (mask[0] == $past(reg_req.wdata)))
    else $error("charge mask write at its offset lost");

  a_alarm_mask_write: assert property ( // [R13]
    @(posedge clk) disable iff (!rstn)
    (reg_req.wr && reg_req.addr == CEFMB_ADDR_MASK_ALARM) |=> (mask[2] == $past(reg_req.wdata)))
    else $error("alarm mask write at its offset lost");

  a_timer_mask_write: assert property ( // [R14]
    @(posedge clk) disable iff (!rstn)
    (reg_req.wr && reg_req.addr == CEFMB_ADDR_MASK_TIMERS) |=> (mask[3] == $past(reg_req.wdata)))
    else $error("timer mask write at its offset lost");

  a_mask_holds_idle: assert property ( // [R14]
    @(posedge clk) disable iff (!rstn)
    !reg_req.wr |=> $stable(mask))
    else $error("mask changed without a write");

  a_first_cycle_quiet: assert property ( // [R17]
    @(posedge clk) disable iff (!rstn)
    first_cycle |-> !irq && !reg_rvalid && (reg_rdata == CEFMB_RDATA_UNMAPPED))
    else $error("outputs not quiet right after reset");

  // A held level must not keep setting a flag after it is read
  a_event_single_hit: assert property ( // [R16]
    @(posedge clk) disable iff (!rstn)
    (event_hit != '0) |=> ((event_hit & $past(event_hit)) == '0))
    else $error("event pulse lasted more than one cycle");

endmodule // cefmb_top
